// file: logic/emb_defines.vh
`ifndef EMB_DEFINES_VH
`define EMB_DEFINES_VH

// Oscillator periods per strobe slot and per machine cycle
`define EMB_SLOT_PERIODS 3'h6
`define EMB_CYCLE_PERIODS 4'hc
// Half period of the system clock output in oscillator periods
`define EMB_SYSTEM_CLOCK_OUTPUT_HALF 3'h6
// Program counter limit of internal program memory
`define EMB_INT_ROM_LIMIT 16'h2000
// Phase counter width and the phases inside one slot
`define EMB_PH_W 3
`define EMB_PH_ALE_HI 3'h0
`define EMB_PH_ALE_LO 3'h2
`define EMB_PH_STB_LO 3'h3
`define EMB_PH_LAST 3'h5
// Bus states
`define EMB_ST_IDLE 2'h0
`define EMB_ST_FETCH 2'h1
`define EMB_ST_DATA 2'h2

`endif

// file: logic/emb_bus.v
`timescale 1ns/100ps
`include "emb_defines.vh"

// Function
// RULE1: Address latch strobe pulses every six oscillator periods, skipped in data accesses.
// RULE2: External latch captures low address on the address latch strobe.
// RULE3: Program store strobe asserted every six periods during external fetch.
// RULE4: Program store strobe stays high while executing from internal memory.
// RULE5: Select high: internal fetch below 8192, external at or above.
// RULE6: Select low: every fetch goes to external program memory.
// RULE7: High address byte driven on upper port during external access.
// RULE8: Lower port carries low address first, then data byte.
// RULE9: System clock output is oscillator divided by 12 when enabled.
// RULE10: External data memory stores lower port byte on write strobe.
// RULE11: External data memory drives lower port only during read strobe.
// RULE12: Low address held through latch strobe fall before switching.
module emb_bus #(
  parameter ADDR_W = 16
) (
  // Clock (one tick = one oscillator period) and reset
  input wire i_mclk,
  input wire i_resetn,
  // Core requests
  input wire [ADDR_W-1:0] i_pc,
  input wire i_data_req,
  input wire i_data_wr,
  input wire [ADDR_W-1:0] i_data_addr,
  input wire [7:0] i_data_wdata,
  input wire i_system_clock_output_en,
  // Pins
  input wire i_external_access_select,
  input wire [7:0] i_low_address_data_port,
  output reg [7:0] o_low_address_data_port,
  output reg o_low_address_data_port_oe,
  output reg [7:0] o_high_address_port,
  output reg o_ale,
  output reg o_program_store_strobe_n,
  output reg o_rd_n,
  output reg o_wr_n,
  output reg o_system_clock_output,
  // Results to core
  output reg [7:0] o_fetch_data,
  output reg o_fetch_valid,
  output reg o_ext_fetch,
  output reg [7:0] o_data_rdata,
  output reg o_data_done
);

  // Slot phase, bus state and data slot count
  reg [`EMB_PH_W-1:0] ph_reg;
  reg [1:0] st_reg;
  reg [1:0] st_next;
  reg [2:0] dslot_reg;
  // System clock divider
  reg [2:0] ck_reg;
  // Fetch source and presented address
  reg ext_sel;
  reg [ADDR_W-1:0] addr_sel;
  // Slot decode
  reg slot_end;
  reg data_cont;
  reg data_open;
  reg data_last;

  // Fetch source decision
  always @* begin
    ext_sel = !i_external_access_select ||                // [RULE6]
              (i_pc >= `EMB_INT_ROM_LIMIT);               // [RULE5]
    addr_sel = i_data_req ? i_data_addr : i_pc;
  end

  // Next bus state at slot boundary
  always @* begin
    st_next = st_reg;
    if (ph_reg == `EMB_PH_LAST) begin
      if (st_reg == `EMB_ST_DATA && dslot_reg != 3'h3) begin
        st_next = `EMB_ST_DATA;
      end else if (i_data_req && st_reg != `EMB_ST_DATA) begin
        st_next = `EMB_ST_DATA;
      end else if (ext_sel) begin
        st_next = `EMB_ST_FETCH;
      end else begin
        st_next = `EMB_ST_IDLE;
      end
    end
  end

  // Slot phase, state and data access length
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ph_reg <= `EMB_PH_ALE_HI;
      st_reg <= `EMB_ST_IDLE;
      dslot_reg <= 3'h0;
    end else begin
      ph_reg <= (ph_reg == `EMB_PH_LAST) ? `EMB_PH_ALE_HI : ph_reg + 3'h1;
      st_reg <= st_next;
      if (ph_reg == `EMB_PH_LAST) begin
        if (st_reg == `EMB_ST_DATA && st_next == `EMB_ST_DATA) begin
          dslot_reg <= dslot_reg + 3'h1;
        end else begin
          dslot_reg <= 3'h0;
        end
      end
    end
  end

  // Slot decode shared by the pin processes
  always @* begin
    slot_end = (ph_reg == `EMB_PH_LAST);
    data_cont = (st_reg == `EMB_ST_DATA) && (st_next == `EMB_ST_DATA);
    // Second data slot opens the strobe, fourth closes it
    data_open = (st_reg == `EMB_ST_DATA) && (dslot_reg == 3'h1);
    data_last = (st_reg == `EMB_ST_DATA) && (dslot_reg == 3'h3);
  end

  // Latch strobe: up at slot start, down three periods later
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ale <= 1'b0;
      o_high_address_port <= 8'h00;
    end else if (slot_end) begin
      // Continuing data slots skip the pulse
      o_ale <= !data_cont;                                // [RULE1]
      // High address only for slots that reach the bus
      if (!data_cont && st_next != `EMB_ST_IDLE) begin
        o_high_address_port <= addr_sel[15:8];            // [RULE7]
      end
    end else if (ph_reg == `EMB_PH_ALE_LO) begin
      o_ale <= 1'b0;                                      // [RULE12]
    end
  end

  // Lower port: address first, then write data or release
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_low_address_data_port <= 8'h00;
      o_low_address_data_port_oe <= 1'b0;
    end else if (slot_end) begin
      if (!data_cont && st_next != `EMB_ST_IDLE) begin
        // New access: drive the low address byte
        o_low_address_data_port <= addr_sel[7:0];         // [RULE8]
        o_low_address_data_port_oe <= 1'b1;
      end else if (data_last) begin
        // Write data held past the strobe, then released
        o_low_address_data_port_oe <= 1'b0;
      end
    end else if (ph_reg == `EMB_PH_STB_LO) begin
      // Port switches only after the latch strobe fell
      if (st_reg == `EMB_ST_FETCH) begin
        o_low_address_data_port_oe <= 1'b0;               // [RULE12]
      end else if (st_reg == `EMB_ST_IDLE) begin
        // Internal execution leaves the port undriven
        o_low_address_data_port_oe <= 1'b0;
      end else if (data_open && i_data_wr) begin
        o_low_address_data_port <= i_data_wdata;          // [RULE8]
      end else if (data_open) begin
        o_low_address_data_port_oe <= 1'b0;               // [RULE12]
      end
    end
  end

  // Program store and data strobes
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_program_store_strobe_n <= 1'b1;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
    end else if (slot_end) begin
      // Fetch strobe ends with the slot
      o_program_store_strobe_n <= 1'b1;
    end else if (ph_reg == `EMB_PH_STB_LO) begin
      if (st_reg == `EMB_ST_FETCH) begin
        o_program_store_strobe_n <= 1'b0;                 // [RULE3]
      end else if (st_reg == `EMB_ST_IDLE) begin
        o_program_store_strobe_n <= 1'b1;                 // [RULE4]
      end else if (data_open) begin
        // One strobe of the two, by direction
        o_wr_n <= !i_data_wr;                             // [RULE10]
        o_rd_n <= i_data_wr;                              // [RULE11]
      end else if (data_last) begin
        // Strobes rise two periods before the port is released
        o_rd_n <= 1'b1;
        o_wr_n <= 1'b1;
      end
    end
  end

  // Results to the core
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fetch_data <= 8'h00;
      o_fetch_valid <= 1'b0;
      o_ext_fetch <= 1'b0;
      o_data_rdata <= 8'h00;
      o_data_done <= 1'b0;
    end else begin
      // Pulses last one period
      o_fetch_valid <= slot_end && (st_reg == `EMB_ST_FETCH);
      o_data_done <= slot_end && data_last;
      o_ext_fetch <= (st_reg == `EMB_ST_FETCH);
      // Fetched byte is taken while the fetch strobe is still low
      if (slot_end && st_reg == `EMB_ST_FETCH) begin
        o_fetch_data <= i_low_address_data_port;
      end
      // Read byte is taken while the read strobe is still low
      if (ph_reg == `EMB_PH_STB_LO && data_last) begin
        o_data_rdata <= i_low_address_data_port;          // [RULE11]
      end
    end
  end

  // System clock output, twelve oscillator periods per cycle
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ck_reg <= 3'h0;
      o_system_clock_output <= 1'b0;
    end else if (ck_reg == `EMB_SYSTEM_CLOCK_OUTPUT_HALF - 3'h1) begin
      // Disabled output parks low at its next toggle point
      ck_reg <= 3'h0;
      o_system_clock_output <= i_system_clock_output_en & ~o_system_clock_output; // [RULE9]
    end else begin
      ck_reg <= ck_reg + 3'h1;
    end
  end

endmodule

// file: sim/emb_mem_model.sv
`timescale 1ns/100ps
// Program and data memory behind an address latch
module emb_mem_model (
  // Strobes
  input wire i_ale,
  input wire i_pstb_n,
  input wire i_rd_n,
  input wire i_wr_n,
  // Address and data
  input wire [7:0] i_ad,
  input wire [7:0] i_hi,
  output wire [7:0] o_ad
);
  reg [7:0] lat_reg;
  reg [7:0] ram [0:255];
  // Address capture on strobe fall
  always @(negedge i_ale) lat_reg = i_ad;
  // Store on write strobe release
  always @(posedge i_wr_n) ram[lat_reg] = i_ad;
  // Drive only under a strobe; pull-ups otherwise
  assign o_ad = !i_rd_n ? ram[lat_reg] :
    !i_pstb_n ? lat_reg ^ i_hi : 8'hff;
endmodule

// file: sim/emb_bus_sva.sv
`timescale 1ns/100ps
module emb_bus_sva (
  // Clock and reset
  input logic i_mclk,
  input logic i_resetn,
  // Bus strobes
  input logic o_ale,
  input logic o_program_store_strobe_n,
  input logic o_rd_n,
  input logic o_wr_n,
  // Lower port
  input logic o_low_address_data_port_oe,
  input logic [7:0] o_low_address_data_port,
  // Status
  input logic o_ext_fetch,
  input logic o_system_clock_output
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  property p_ale_gap; $rose(o_ale) |=> (!$rose(o_ale))[*5]; endproperty
  a_ale_gap:
    assert property (p_ale_gap) else $error("ale too soon");
  property p_ale_skip; !o_rd_n || !o_wr_n |-> !o_ale; endproperty
  a_ale_skip:
    assert property (p_ale_skip) else $error("ale in data access");
  property p_ale_addr; o_ale && o_low_address_data_port_oe |=>
    o_low_address_data_port_oe && $stable(o_low_address_data_port);
  endproperty
  a_ale_addr:
    assert property (p_ale_addr) else $error("address moved under ale");
  property p_ale_hold;
    $fell(o_ale) && $past(o_low_address_data_port_oe) |->
    o_low_address_data_port_oe && $stable(o_low_address_data_port);
  endproperty
  a_ale_hold:
    assert property (p_ale_hold) else $error("address not held");
  property p_fetch_addr; $fell(o_program_store_strobe_n) |->
    $past(o_ale, 2) && $past(o_low_address_data_port_oe, 2); endproperty
  a_fetch_addr:
    assert property (p_fetch_addr) else $error("fetch without address");
  property p_pstb_int;
    (!o_ext_fetch)[*7] |-> o_program_store_strobe_n; endproperty
  a_pstb_int:
    assert property (p_pstb_int) else $error("strobe in internal run");
  property p_pstb_ext; $fell(o_program_store_strobe_n) |-> o_ext_fetch &&
    !o_ale ##[1:4] o_program_store_strobe_n; endproperty
  a_pstb_ext:
    assert property (p_pstb_ext) else $error("bad fetch strobe");
  property p_rd_bus; !o_rd_n |-> !o_low_address_data_port_oe; endproperty
  a_rd_bus:
    assert property (p_rd_bus) else $error("port driven in read");
  property p_wr_bus;
    !o_wr_n |-> o_low_address_data_port_oe && o_program_store_strobe_n;
  endproperty
  a_wr_bus:
    assert property (p_wr_bus) else $error("bad write cycle");
  property p_clk; $rose(o_system_clock_output) |=>
    o_system_clock_output[*5] ##1 !o_system_clock_output; endproperty
  a_clk:
    assert property (p_clk) else $error("clock output period");
endmodule
bind emb_bus emb_bus_sva u_sva (.*);

// file: sim/test_external_memory_bus_strobes.sv
`timescale 1ns/100ps
module test_external_memory_bus_strobes;
  reg i_mclk = 0, i_resetn = 0, i_data_req = 0, i_data_wr = 0;
  reg i_system_clock_output_en = 1, i_external_access_select = 1;
  reg [15:0] i_pc = 0, i_data_addr = 0, ra;
  reg [7:0] i_data_wdata = 0, rd, fexp;
  wire [7:0] o_low_address_data_port, o_high_address_port, mem_ad;
  wire [7:0] o_fetch_data, o_data_rdata;
  wire o_low_address_data_port_oe, o_ale, o_program_store_strobe_n;
  wire o_rd_n, o_wr_n, o_system_clock_output, o_fetch_valid;
  wire o_ext_fetch, o_data_done;
  wire [7:0] i_low_address_data_port =
    o_low_address_data_port_oe ? o_low_address_data_port : mem_ad;
  integer mismatches = 0, total_checks = 0, nf = 0, n0, i, k, nc;
  logic [8:0] q[$];
  logic fon = 0, ext, ck_d;
  always #2 i_mclk = ~i_mclk;
  emb_bus dut (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_pc(i_pc),
    .i_data_req(i_data_req), .i_data_wr(i_data_wr),
    .i_data_addr(i_data_addr), .i_data_wdata(i_data_wdata),
    .i_system_clock_output_en(i_system_clock_output_en),
    .i_external_access_select(i_external_access_select),
    .i_low_address_data_port(i_low_address_data_port),
    .o_low_address_data_port(o_low_address_data_port),
    .o_low_address_data_port_oe(o_low_address_data_port_oe),
    .o_high_address_port(o_high_address_port), .o_ale(o_ale),
    .o_program_store_strobe_n(o_program_store_strobe_n),
    .o_rd_n(o_rd_n), .o_wr_n(o_wr_n),
    .o_system_clock_output(o_system_clock_output),
    .o_fetch_data(o_fetch_data), .o_fetch_valid(o_fetch_valid),
    .o_ext_fetch(o_ext_fetch), .o_data_rdata(o_data_rdata),
    .o_data_done(o_data_done));
  emb_mem_model mem (.i_ale(o_ale), .i_pstb_n(o_program_store_strobe_n),
    .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_ad(i_low_address_data_port),
    .i_hi(o_high_address_port), .o_ad(mem_ad));
  task check(input [7:0] s, e, input string n);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One data access, expectation queued first
  task data(input w, input [15:0] a, input [7:0] d);
    @(negedge i_mclk);
    {i_data_req, i_data_wr, i_data_addr, i_data_wdata} = {1'b1, w, a, d};
    q.push_back({!w, d});
    for (n0 = 0; n0 < 60 && o_data_done !== 1'b1; n0++) @(negedge i_mclk);
    if (n0 == 60) begin
      mismatches++;
      finish_test;
    end
    i_data_req = 0;
  endtask
  // Result watcher
  always @(posedge i_mclk) begin
    if (o_fetch_valid) nf++;
    if (o_fetch_valid && fon) check(o_fetch_data, fexp, "fetch");
    if (o_data_done && q.size() > 0) begin
      k = q.pop_front();
      if (k[8]) check(o_data_rdata, k[7:0], "rdata");
    end
  end
  initial begin
    k = $urandom(32'h4385);
    repeat (8) @(negedge i_mclk);
    i_resetn = 1;
    // Internal and external fetch cases
    for (i = 0; i < 4; i++) begin
      i_external_access_select = (i != 3);
      i_pc = i == 1 ? 16'h1fff : i == 2 ? 16'h2000 + $urandom % 16'he000 :
        $urandom % 16'h2000;
      ext = !i_external_access_select || i_pc >= 16'h2000;
      fexp = i_pc[7:0] ^ i_pc[15:8];
      repeat (12) @(negedge i_mclk);
      n0 = nf;
      fon = 1;
      repeat (18) @(negedge i_mclk);
      fon = 0;
      check(nf != n0, ext, "ext fetch");
      check(o_ext_fetch, ext, "ext slot");
      if (ext)
        check(o_high_address_port, i_pc[15:8], "high addr");
    end
    // System clock output: ten rises in 120 periods, none when disabled
    for (i = 0; i < 2; i++) begin
      i_system_clock_output_en = (i == 0);
      repeat (12) @(negedge i_mclk);
      nc = 0;
      for (n0 = 0; n0 < 120; n0++) begin
        ck_d = o_system_clock_output;
        @(negedge i_mclk);
        if (o_system_clock_output === 1'b1 && ck_d === 1'b0) nc++;
      end
      check(nc, (i == 0) ? 8'h0a : 8'h00, "clock rises");
    end
    check(o_system_clock_output, 8'h00, "clock parked");
    i_system_clock_output_en = 1;
    // Back-to-back write and read
    for (i = 0; i < 3; i++) begin
      ra = $urandom;
      rd = $urandom;
      data(1, ra, rd);
      data(0, ra, rd);
    end
    finish_test;
  end
endmodule
